// ===== hdl/analog_reference_loss_monitor.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module analog_reference_loss_monitor #(
  parameter int CYC_PER_MS = ref_loss_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] voltage_reference_input,
  input wire logic [15:0] current_reference_input,
  input wire logic run_cmd,
  output logic [15:0] freq_ref,
  output logic drive_run,
  output logic voltage_reference_loss_flag,
  output logic current_reference_loss_flag,
  output logic loss_trip,
  output logic loss_hold
);
  //////////////////////////////////////////////////////////////////////////////
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [5:0] ctrl_r;
  logic [15:0] loss_dly_r;
  logic [15:0] max_freq_r;
  logic [15:0] decel_r;
  logic [31:0] rd_val;
  logic ap_valid;
  logic wr_now;
  logic [15:0] wdat;
  logic ms_tick;
  logic [31:0] ms_div_r;
  logic reference_source_select;
  logic latch_en;
  ref_loss_pkg::crit_t crit;
  ref_loss_pkg::action_t action;
  ref_loss_pkg::loss_state_t state_r;

  assign ap_valid = hsel & hready & htrans[1];
  assign wr_now = wr_pend_r;
  assign wdat = hwdata[15:0];
  assign reference_source_select = ctrl_r[ref_loss_pkg::CTRL_SRC_BIT];
  assign latch_en = ctrl_r[ref_loss_pkg::CTRL_LATCH_BIT];
  assign crit = ref_loss_pkg::crit_t'(ctrl_r[ref_loss_pkg::CTRL_CRIT_LSB +: 2]);
  assign action = ref_loss_pkg::action_t'(ctrl_r[ref_loss_pkg::CTRL_ACT_LSB +: 2]);

  // zero wait states: writes land in the data phase, reads are sampled
  // in the address phase so hrdata comes straight from a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= ap_valid & hwrite;
      wr_addr_r <= haddr[7:0];
      if (ap_valid && !hwrite) begin
        hrdata <= rd_val;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= ref_loss_pkg::RST_CTRL;
      loss_dly_r <= ref_loss_pkg::RST_LOSS_DLY;
      max_freq_r <= ref_loss_pkg::RST_MAX_FREQ;
      decel_r <= ref_loss_pkg::RST_DECEL;
    end else if (wr_now) begin
      if (wr_addr_r == ref_loss_pkg::OFF_CTRL) begin
        ctrl_r <= hwdata[5:0];
      end else if (wr_addr_r == ref_loss_pkg::OFF_LOSS_DLY) begin
        loss_dly_r <= wdat;
      end else if (wr_addr_r == ref_loss_pkg::OFF_MAX_FREQ) begin
        max_freq_r <= wdat;
      end else if (wr_addr_r == ref_loss_pkg::OFF_DECEL) begin
        decel_r <= wdat;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_div_r <= 32'h0000_0000;
    end else if (ms_tick) begin
      ms_div_r <= 32'h0000_0000;
    end else begin
      ms_div_r <= ms_div_r + 32'h0000_0001;
    end
  end
  assign ms_tick = (ms_div_r == 32'(CYC_PER_MS - 1));

  //////////////////////////////////////////////////////////////////////////////
  // channel 0 is the voltage input, channel 1 the current input
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : ch_g
      localparam logic [7:0] BASE = 8'(ref_loss_pkg::OFF_CH_BASE + ch * ref_loss_pkg::CH_STRIDE);
      localparam logic [15:0] LIMIT = (ch == 0) ? ref_loss_pkg::V_LIMIT : ref_loss_pkg::I_LIMIT;
      logic [15:0] filt_r;
      logic [15:0] smin_r;
      logic [15:0] fmin_r;
      logic [15:0] smax_r;
      logic [15:0] fmax_r;
      logic [15:0] smin_cap;
      logic [15:0] x;
      logic [31:0] tick_cnt_r;
      logic [31:0] tick_len;
      logic signed [24:0] acc_r;
      logic signed [24:0] diff;
      logic [15:0] y;

      assign x = (ch == 0) ? voltage_reference_input : current_reference_input;
      // voltage low endpoint may not pass the high one; current has a fixed cap
      assign smin_cap = (ch == 0) ? smax_r : LIMIT;

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          filt_r <= (ch == 0) ? ref_loss_pkg::RST_FILT_V_MS : ref_loss_pkg::RST_FILT_I_MS;
          smin_r <= (ch == 0) ? ref_loss_pkg::RST_V_MIN : ref_loss_pkg::RST_I_MIN;
          fmin_r <= ref_loss_pkg::RST_F_MIN;
          smax_r <= (ch == 0) ? ref_loss_pkg::RST_V_MAX : ref_loss_pkg::RST_I_MAX;
          fmax_r <= ref_loss_pkg::RST_F_MAX;
        end else if (wr_now) begin
          if (wr_addr_r == BASE + 8'(4 * ref_loss_pkg::K_FILT)) begin
            filt_r <= wdat;
          end else if (wr_addr_r == BASE + 8'(4 * ref_loss_pkg::K_SMIN)) begin
            smin_r <= (wdat > smin_cap) ? smin_cap : wdat;
          end else if (wr_addr_r == BASE + 8'(4 * ref_loss_pkg::K_FMIN)) begin
            fmin_r <= (wdat > max_freq_r) ? max_freq_r : wdat;
          end else if (wr_addr_r == BASE + 8'(4 * ref_loss_pkg::K_SMAX)) begin
            smax_r <= (wdat > LIMIT) ? LIMIT : wdat;
            // lowering the voltage high endpoint drags the low one along
            if (ch == 0 && wdat < smin_r) begin
              smin_r <= wdat;
            end
          end else if (wr_addr_r == BASE + 8'(4 * ref_loss_pkg::K_FMAX)) begin
            fmax_r <= (wdat > max_freq_r) ? max_freq_r : wdat;
          end
        end
      end

      // alpha of 1/16 applied every filter/16 ms gives tau = filter time
      assign tick_len = 32'((filt_r * CYC_PER_MS) >> ref_loss_pkg::FILT_SHIFT);
      assign diff = $signed({1'b0, x, 8'h00}) - acc_r;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tick_cnt_r <= 32'h0000_0000;
          acc_r <= 25'sh0000000;
        end else if (filt_r == 16'h0000) begin
          tick_cnt_r <= 32'h0000_0000;
          acc_r <= $signed({1'b0, x, 8'h00});
        end else if (tick_cnt_r + 32'h0000_0001 >= tick_len) begin
          tick_cnt_r <= 32'h0000_0000;
          acc_r <= acc_r + (diff >>> ref_loss_pkg::FILT_SHIFT);
        end else begin
          tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
      end
      assign y = acc_r[23:8];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  logic [15:0] y_a;
  logic [15:0] smin_a;
  logic [15:0] smax_a;
  logic [15:0] fmin_a;
  logic [15:0] fmax_a;
  logic [15:0] y_c;
  logic signed [33:0] span_prod;
  logic signed [33:0] lin_s;
  logic [15:0] lin;
  logic loss_raw;

  always_comb begin
    if (reference_source_select) begin
      y_a = ch_g[1].y;
      smin_a = ch_g[1].smin_r;
      smax_a = ch_g[1].smax_r;
      fmin_a = ch_g[1].fmin_r;
      fmax_a = ch_g[1].fmax_r;
    end else begin
      y_a = ch_g[0].y;
      smin_a = ch_g[0].smin_r;
      smax_a = ch_g[0].smax_r;
      fmin_a = ch_g[0].fmin_r;
      fmax_a = ch_g[0].fmax_r;
    end
  end

  // clamp then interpolate; a degenerate span pins the output to fmin
  always_comb begin
    y_c = (y_a < smin_a) ? smin_a : ((y_a > smax_a) ? smax_a : y_a);
    span_prod = $signed({18'h00000, y_c - smin_a}) * ($signed({18'h00000, fmax_a})
                - $signed({18'h00000, fmin_a}));
    if (smax_a > smin_a) begin
      lin_s = $signed({18'h00000, fmin_a})
              + span_prod / $signed({18'h00000, smax_a - smin_a});
    end else begin
      lin_s = $signed({18'h00000, fmin_a});
    end
    lin = lin_s[15:0];
  end

  always_comb begin
    if (crit == ref_loss_pkg::CRIT_NONE || smin_a == 16'h0000) begin
      loss_raw = 1'b0;
    end else if (crit == ref_loss_pkg::CRIT_HALF) begin
      loss_raw = ({y_a, 1'b0} < {1'b0, smin_a});
    end else if (crit == ref_loss_pkg::CRIT_BELOW) begin
      loss_raw = (y_a < smin_a);
    end else begin
      loss_raw = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed history: one sample per second, the older one is 1 to 2 s back
  logic [15:0] hist_r [2];
  logic [15:0] hist_ms_r;
  logic [15:0] hold_speed_r;
  logic [31:0] dly_ms_r;
  logic [31:0] dly_target;
  logic [23:0] ramp_r;
  logic [23:0] ramp_step;
  logic act_stop;

  assign dly_target = 32'(loss_dly_r * ref_loss_pkg::DLY_UNIT_MS);
  assign ramp_step = (decel_r == 16'h0000) ? {max_freq_r, 8'h00}
                     : 24'({max_freq_r, 8'h00} / (decel_r * ref_loss_pkg::DLY_UNIT_MS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_ms_r <= 16'h0000;
      hist_r[0] <= 16'h0000;
      hist_r[1] <= 16'h0000;
    end else if (ms_tick) begin
      if (hist_ms_r == 16'(ref_loss_pkg::HIST_STEP_MS - 1)) begin
        hist_ms_r <= 16'h0000;
        hist_r[0] <= freq_ref;
        hist_r[1] <= hist_r[0];
      end else begin
        hist_ms_r <= hist_ms_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ref_loss_pkg::ST_OK;
      dly_ms_r <= 32'h0000_0000;
      hold_speed_r <= 16'h0000;
    end else begin
      case (state_r)
        ref_loss_pkg::ST_OK: begin
          dly_ms_r <= 32'h0000_0000;
          if (loss_raw) begin
            state_r <= ref_loss_pkg::ST_PEND;
            hold_speed_r <= hist_r[1];
          end
        end
        ref_loss_pkg::ST_PEND: begin
          if (!loss_raw) begin
            state_r <= ref_loss_pkg::ST_OK;
          end else if (dly_ms_r >= dly_target) begin
            state_r <= ref_loss_pkg::ST_ACT;
          end else if (ms_tick) begin
            dly_ms_r <= dly_ms_r + 32'h0000_0001;
          end
        end
        ref_loss_pkg::ST_ACT: begin
          // latched trips survive signal return until reset or latch off
          if (!loss_raw && !latch_en) begin
            state_r <= ref_loss_pkg::ST_OK;
          end
        end
        default: state_r <= ref_loss_pkg::ST_OK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_r <= 24'h000000;
    end else if (state_r != ref_loss_pkg::ST_ACT) begin
      ramp_r <= {freq_ref, 8'h00};
    end else if (action == ref_loss_pkg::ACT_DECEL && ms_tick) begin
      ramp_r <= (ramp_r > ramp_step) ? ramp_r - ramp_step : 24'h000000;
    end
  end

  assign act_stop = (state_r == ref_loss_pkg::ST_ACT) &&
                    (action == ref_loss_pkg::ACT_COAST || action == ref_loss_pkg::ACT_TRIP ||
                     (action == ref_loss_pkg::ACT_DECEL && ramp_r[23:8] == 16'h0000));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_ref <= 16'h0000;
      drive_run <= 1'b0;
      loss_trip <= 1'b0;
      loss_hold <= 1'b0;
      voltage_reference_loss_flag <= 1'b0;
      current_reference_loss_flag <= 1'b0;
    end else begin
      if (state_r != ref_loss_pkg::ST_ACT) begin
        freq_ref <= lin;
      end else if (action == ref_loss_pkg::ACT_HOLD) begin
        freq_ref <= hold_speed_r;
      end else if (action == ref_loss_pkg::ACT_DECEL) begin
        freq_ref <= ramp_r[23:8];
      end else begin
        freq_ref <= 16'h0000;
      end
      drive_run <= run_cmd & ~act_stop;
      loss_trip <= (state_r == ref_loss_pkg::ST_ACT) && (action == ref_loss_pkg::ACT_TRIP);
      loss_hold <= (state_r == ref_loss_pkg::ST_ACT) && (action == ref_loss_pkg::ACT_HOLD);
      voltage_reference_loss_flag <= (state_r == ref_loss_pkg::ST_ACT) && !reference_source_select;
      current_reference_loss_flag <= (state_r == ref_loss_pkg::ST_ACT) && reference_source_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[7:0] == ref_loss_pkg::OFF_CTRL) begin
      rd_val = {26'h0000000, ctrl_r};
    end else if (haddr[7:0] == ref_loss_pkg::OFF_LOSS_DLY) begin
      rd_val = {16'h0000, loss_dly_r};
    end else if (haddr[7:0] == ref_loss_pkg::OFF_MAX_FREQ) begin
      rd_val = {16'h0000, max_freq_r};
    end else if (haddr[7:0] == ref_loss_pkg::OFF_DECEL) begin
      rd_val = {16'h0000, decel_r};
    end else if (haddr[7:0] == ref_loss_pkg::OFF_STATUS) begin
      rd_val = {y_a, 8'h00, loss_raw, state_r, loss_hold, loss_trip,
                current_reference_loss_flag, voltage_reference_loss_flag, drive_run};
    end else if (haddr[7:0] == ref_loss_pkg::OFF_FREQ) begin
      rd_val = {16'h0000, freq_ref};
    end else if (haddr[7:0] >= ref_loss_pkg::OFF_CH_BASE
                 && haddr[7:0] < ref_loss_pkg::OFF_LOSS_DLY) begin
      rd_val = {16'h0000, chan_word(haddr[7:0] - ref_loss_pkg::OFF_CH_BASE)};
    end
  end

  function automatic logic [15:0] chan_word(input logic [7:0] rel);
    logic [15:0] w;
    w = 16'h0000;
    case (rel)
      8'h00: w = ch_g[0].filt_r;
      8'h04: w = ch_g[0].smin_r;
      8'h08: w = ch_g[0].fmin_r;
      8'h0c: w = ch_g[0].smax_r;
      8'h10: w = ch_g[0].fmax_r;
      8'h14: w = ch_g[1].filt_r;
      8'h18: w = ch_g[1].smin_r;
      8'h1c: w = ch_g[1].fmin_r;
      8'h20: w = ch_g[1].smax_r;
      8'h24: w = ch_g[1].fmax_r;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_NONE_NO_LOSS: assert property (crit == ref_loss_pkg::CRIT_NONE |-> !loss_raw)
    else $error("loss raised with criterion none");
  AST_ZERO_MIN: assert property (smin_a == 16'h0000 |-> !loss_raw)
    else $error("loss raised with zero low endpoint");
  AST_BELOW: assert property ((crit == ref_loss_pkg::CRIT_BELOW && smin_a != 16'h0000
      && y_a < smin_a) |-> loss_raw) else $error("below-minimum loss missed");
  AST_HALF: assert property ((crit == ref_loss_pkg::CRIT_HALF
      && {y_a, 1'b0} >= {1'b0, smin_a}) |-> !loss_raw)
    else $error("half-minimum loss raised above threshold");
  AST_DELAY: assert property ($rose(state_r == ref_loss_pkg::ST_ACT)
      |-> $past(state_r) == ref_loss_pkg::ST_PEND && $past(dly_ms_r) >= $past(dly_target))
    else $error("loss action before delay");
  AST_LATCH: assert property ((state_r == ref_loss_pkg::ST_ACT && latch_en)
      |=> state_r == ref_loss_pkg::ST_ACT) else $error("latched loss released");
  AST_UNLATCH: assert property ((state_r == ref_loss_pkg::ST_ACT && !latch_en && !loss_raw)
      |=> state_r == ref_loss_pkg::ST_OK) else $error("unlatched loss not cleared");
  AST_COAST: assert property ((state_r == ref_loss_pkg::ST_ACT
      && action == ref_loss_pkg::ACT_COAST) |=> freq_ref == 16'h0000 && !drive_run)
    else $error("coast action left output running");
  AST_TRIP: assert property ((state_r == ref_loss_pkg::ST_ACT
      && action == ref_loss_pkg::ACT_TRIP) |=> loss_trip) else $error("trip not reported");
  AST_VMIN_BOUND: assert property (ch_g[0].smin_r <= ch_g[0].smax_r)
    else $error("voltage low endpoint above high endpoint");
endmodule

// ===== hdl/ref_loss_pkg.sv
package ref_loss_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CH_BASE = 8'h04;
  localparam logic [7:0] CH_STRIDE = 8'h14;
  localparam logic [7:0] OFF_LOSS_DLY = 8'h2c;
  localparam logic [7:0] OFF_MAX_FREQ = 8'h30;
  localparam logic [7:0] OFF_DECEL = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  localparam logic [7:0] OFF_FREQ = 8'h3c;
  // per-channel word order: filter, sig min, freq min, sig max, freq max
  localparam int K_FILT = 0;
  localparam int K_SMIN = 1;
  localparam int K_FMIN = 2;
  localparam int K_SMAX = 3;
  localparam int K_FMAX = 4;
  // control field positions
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_CRIT_LSB = 2;
  localparam int CTRL_ACT_LSB = 4;

  typedef enum logic [1:0] {CRIT_NONE = 2'b00, CRIT_HALF = 2'b01, CRIT_BELOW = 2'b10} crit_t;
  typedef enum logic [1:0] {
    ACT_HOLD = 2'b00, ACT_DECEL = 2'b01, ACT_COAST = 2'b10, ACT_TRIP = 2'b11
  } action_t;
  typedef enum logic [1:0] {ST_OK = 2'b00, ST_PEND = 2'b01, ST_ACT = 2'b10} loss_state_t;

  // reset values; signals in 0.01 V / 0.01 mA, frequency in 0.01 Hz
  localparam logic [15:0] RST_FILT_V_MS = 16'h00c8;
  localparam logic [15:0] RST_FILT_I_MS = 16'h0064;
  localparam logic [15:0] RST_V_MIN = 16'h0000;
  localparam logic [15:0] RST_V_MAX = 16'h03e8;
  localparam logic [15:0] V_LIMIT = 16'h04b0;
  localparam logic [15:0] RST_I_MIN = 16'h0190;
  localparam logic [15:0] RST_I_MAX = 16'h07d0;
  localparam logic [15:0] I_LIMIT = 16'h07d0;
  localparam logic [15:0] RST_F_MIN = 16'h0000;
  localparam logic [15:0] RST_F_MAX = 16'h1770;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
  localparam logic [15:0] RST_LOSS_DLY = 16'h000a;
  localparam logic [15:0] RST_DECEL = 16'h0064;
  localparam logic [5:0] RST_CTRL = 6'h20;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int DLY_UNIT_MS = 100;
  localparam int HOLD_BACK_MS = 2000;
  localparam int HIST_STEP_MS = HOLD_BACK_MS / 2;
  localparam int FILT_SHIFT = 4;
endpackage

// ===== verif/analog_ref_source.sv
`timescale 1ns/1ps
// transducer model; slow mode slews one count a clock like a settling sensor
module analog_ref_source (
  input wire logic clk,
  input wire logic slow,
  input wire logic [15:0] v_target,
  input wire logic [15:0] i_target,
  output logic [15:0] v_out,
  output logic [15:0] i_out
);
  function automatic logic [15:0] step(logic [15:0] cur, logic [15:0] tgt, logic s);
    if (!s || cur == tgt) begin
      return tgt;
    end
    return (cur < tgt) ? cur + 16'h0001 : cur - 16'h0001;
  endfunction

  always_ff @(posedge clk) begin
    v_out <= step(v_out, v_target, slow);
    i_out <= step(i_out, i_target, slow);
  end
endmodule

// ===== verif/analog_reference_loss_monitor_test.sv
`timescale 1ns/1ps
module analog_reference_loss_monitor_test;
  logic clk, rst_b, hsel, hwrite, run_cmd, slow, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [15:0] v_tgt, i_tgt, vin, iin, freq_ref;
  logic drive_run, vflag, iflag, loss_trip, loss_hold;
  int mismatches, checked, seed, x;

  analog_reference_loss_monitor #(.CYC_PER_MS(2)) u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .voltage_reference_input(vin),
    .current_reference_input(iin), .run_cmd(run_cmd), .freq_ref(freq_ref),
    .drive_run(drive_run), .voltage_reference_loss_flag(vflag),
    .current_reference_loss_flag(iflag), .loss_trip(loss_trip), .loss_hold(loss_hold)
  );
  analog_ref_source u_src (
    .clk(clk), .slow(slow), .v_target(v_tgt), .i_target(i_tgt), .v_out(vin), .i_out(iin)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        mismatches++;
        give_verdict();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    wait_rdy();
    rd = hrdata;
    check(rd, {16'h0000, e});
    check(hresp, 1'b0);
  endtask

  function automatic logic [7:0] ch(int c, int k);
    return 8'(ref_loss_pkg::OFF_CH_BASE + c * ref_loss_pkg::CH_STRIDE + 4 * k);
  endfunction

  function automatic int fexp(int v, int smin, int smax, int fmin, int fmax);
    if (v < smin) v = smin;
    if (v > smax) v = smax;
    return fmin + (v - smin) * (fmax - fmin) / (smax - smin);
  endfunction

  // delay register is 1 (100 ms = 200 cycles); check just before and just after it
  task automatic run_loss(input logic [7:0] c, input logic [15:0] smin, input logic [15:0] low,
                          input logic lost, input int pre);
    bus_wr(ch(0, 1), {16'h0000, smin});
    bus_wr(ref_loss_pkg::OFF_CTRL, {24'h000000, c});
    v_tgt <= 16'd600;
    repeat (pre) @(posedge clk);
    v_tgt <= low;
    repeat (180) @(posedge clk);
    check(drive_run, 1'b1);
    repeat (60) @(posedge clk);
    check(vflag, lost);
  endtask

  task automatic back();
    v_tgt <= 16'd600;
    repeat (20) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    run_cmd = 1'b0;
    slow = 1'b0;
    v_tgt = '0;
    i_tgt = '0;
    mismatches = 0;
    checked = 0;
    seed = 63446;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    run_cmd <= 1'b1;
    @(posedge clk);
    rchk(ref_loss_pkg::OFF_CTRL, {10'h000, ref_loss_pkg::RST_CTRL});
    rchk(ch(0, 0), ref_loss_pkg::RST_FILT_V_MS);
    rchk(ch(1, 0), ref_loss_pkg::RST_FILT_I_MS);
    rchk(ch(0, 1), ref_loss_pkg::RST_V_MIN);
    rchk(ch(0, 3), ref_loss_pkg::RST_V_MAX);
    rchk(ch(0, 2), ref_loss_pkg::RST_F_MIN);
    rchk(ch(1, 4), ref_loss_pkg::RST_F_MAX);
    rchk(ch(1, 1), ref_loss_pkg::RST_I_MIN);
    rchk(ch(1, 3), ref_loss_pkg::RST_I_MAX);
    rchk(ref_loss_pkg::OFF_LOSS_DLY, ref_loss_pkg::RST_LOSS_DLY);
    rchk(8'h40, 16'h0000);
    v_tgt <= 16'd1000;
    repeat (40) @(posedge clk);
    check(freq_ref < 16'd6000, 1'b1);
    check(freq_ref > 16'd0, 1'b1);
    bus_wr(ch(0, 3), 32'd2000);
    rchk(ch(0, 3), ref_loss_pkg::V_LIMIT);
    bus_wr(ch(0, 1), 32'd1500);
    rchk(ch(0, 1), ref_loss_pkg::V_LIMIT);
    bus_wr(ch(1, 1), 32'd3000);
    rchk(ch(1, 1), ref_loss_pkg::I_LIMIT);
    bus_wr(ch(1, 3), 32'd3000);
    rchk(ch(1, 3), ref_loss_pkg::I_LIMIT);
    bus_wr(ch(0, 4), 32'd9000);
    rchk(ch(0, 4), ref_loss_pkg::RST_MAX_FREQ);
    bus_wr(ch(0, 1), 32'd0);
    bus_wr(ch(0, 3), 32'd1000);
    bus_wr(ch(1, 1), 32'd400);
    bus_wr(ch(0, 0), 32'd0);
    bus_wr(ch(1, 0), 32'd0);
    bus_wr(ref_loss_pkg::OFF_LOSS_DLY, 32'd1);
    slow <= 1'b1;
    repeat (8) begin
      x = $unsigned($random(seed)) % 1200;
      v_tgt <= 16'(x);
      repeat (1300) @(posedge clk);
      check(freq_ref, fexp(x, 0, 1000, 0, 6000));
    end
    slow <= 1'b0;
    bus_wr(ref_loss_pkg::OFF_CTRL, 32'h21);
    i_tgt <= 16'd1200;
    v_tgt <= 16'd0;
    repeat (5) @(posedge clk);
    check(freq_ref, 32'd3000);
    // current source lost: only the current flag may rise
    bus_wr(ref_loss_pkg::OFF_CTRL, 32'h29);
    i_tgt <= 16'd300;
    repeat (240) @(posedge clk);
    check(iflag, 1'b1);
    check(vflag, 1'b0);
    i_tgt <= 16'd1200;
    run_loss(8'h28, 16'd200, 16'd150, 1'b1, 10);
    check(drive_run, 1'b0);
    check(freq_ref, 32'd0);
    back();
    check(drive_run, 1'b1);
    check(freq_ref, 32'd3000);
    run_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    check(drive_run, 1'b0);
    run_cmd <= 1'b1;
    run_loss(8'h20, 16'd200, 16'd0, 1'b0, 10);
    back();
    run_loss(8'h24, 16'd200, 16'd150, 1'b0, 10);
    back();
    run_loss(8'h24, 16'd200, 16'd90, 1'b1, 10);
    back();
    run_loss(8'h28, 16'd0, 16'd0, 1'b0, 10);
    back();
    run_loss(8'h38, 16'd200, 16'd150, 1'b1, 10);
    check(loss_trip, 1'b1);
    back();
    check(loss_trip, 1'b0);
    run_loss(8'h3a, 16'd200, 16'd150, 1'b1, 10);
    back();
    check(loss_trip, 1'b1);
    bus_wr(ref_loss_pkg::OFF_CTRL, 32'h38);
    repeat (5) @(posedge clk);
    check(loss_trip, 1'b0);
    run_loss(8'h08, 16'd200, 16'd150, 1'b1, 4400);
    check(loss_hold, 1'b1);
    check(freq_ref, 32'd3000);
    back();
    // nonzero low frequency so the ramp starts from 12 Hz and takes about 80 clocks
    bus_wr(ch(0, 2), 32'd1200);
    bus_wr(ref_loss_pkg::OFF_DECEL, 32'd2);
    run_loss(8'h18, 16'd200, 16'd150, 1'b1, 10);
    check(freq_ref > 16'd0 && freq_ref < 16'd1200, 1'b1);
    check(drive_run, 1'b1);
    x = 0;
    while (drive_run !== 1'b0 && x < 400) begin
      x++;
      @(posedge clk);
    end
    check(freq_ref, 32'd0);
    check(drive_run, 1'b0);
    give_verdict();
  end
endmodule
